// ==== common/tecl_pkg.sv ====
// constants, field layouts and carrier types of the thermal event configuration logic
// assumes one core clock domain; temperatures are 13-bit two's complement, 0.0625 C per lsb
package tecl_pkg;

  // ---------------------------------------------------------------
  // register pointer values
  // ---------------------------------------------------------------
  localparam logic [2:0] PTR_CAPA  = 3'h0;
  localparam logic [2:0] PTR_SENSOR_CONFIGURATION  = 3'h1;
  localparam logic [2:0] PTR_UPPER = 3'h2;
  localparam logic [2:0] PTR_LOWER = 3'h3;
  localparam logic [2:0] PTR_CRIT  = 3'h4;
  localparam logic [2:0] PTR_TEMP  = 3'h5;
  localparam logic [2:0] PTR_MANU  = 3'h6;
  localparam logic [2:0] PTR_DEVID = 3'h7;

  // ---------------------------------------------------------------
  // configuration register field positions
  // ---------------------------------------------------------------
  localparam int CFG_MODE_BIT     = 0;
  localparam int CFG_POLARITY_BIT = 1;
  localparam int CFG_CRITONLY_BIT = 2;
  localparam int CFG_OUTCTL_BIT   = 3;
  localparam int CFG_STATUS_BIT   = 4;
  localparam int CFG_CLEAR_BIT    = 5;
  localparam int CFG_ALOCK_BIT    = 6;
  localparam int CFG_CLOCK_BIT    = 7;
  localparam int CFG_SHDN_BIT     = 8;
  localparam int CFG_HYST_LO      = 9;
  localparam int CFG_HYST_HI      = 10;

  // ---------------------------------------------------------------
  // reset values, masks and hysteresis sizes
  // ---------------------------------------------------------------
  localparam logic [15:0] CFG_RESET    = 16'h0000;
  localparam logic [15:0] LIMIT_RESET  = 16'h0000;
  localparam logic [15:0] CAPA_VALUE   = 16'h002F;
  localparam logic [15:0] LIMIT_MASK   = 16'h1FFF;
  localparam int          TEMP_W       = 13;
  localparam logic [6:0]  HYS_LSB_0    = 7'h00;  // disabled
  localparam logic [6:0]  HYS_LSB_1P5  = 7'h18;  // 1.5 C
  localparam logic [6:0]  HYS_LSB_3    = 7'h30;  // 3 C
  localparam logic [6:0]  HYS_LSB_6    = 7'h60;  // 6 C

  // ---------------------------------------------------------------
  // trip comparator indices and their sense
  // ---------------------------------------------------------------
  localparam int         TRIP_BELOW   = 0;
  localparam int         TRIP_ABOVE   = 1;
  localparam int         TRIP_CRIT    = 2;
  localparam int         TRIP_N       = 3;
  localparam logic [2:0] TRIP_RISING  = 3'h6;  // above and critical trip on rising
  localparam logic [2:0] TRIP_INCLUDE = 3'h4;  // critical trips at equality

  // ---------------------------------------------------------------
  // carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] hyst;
    logic       shutdown;
    logic       critLock;
    logic       alarmLock;
    logic       outCtl;
    logic       critOnly;
    logic       polarity;
    logic       evtMode;
  } tecl_cfg_s;

  typedef enum logic {INT_IDLE, INT_PENDING} tecl_int_e;

  // hysteresis code to temperature lsb count
  function automatic logic [6:0] tecl_hys_lsb(input logic [1:0] code);
    case (code)
      2'h1:    tecl_hys_lsb = HYS_LSB_1P5;
      2'h2:    tecl_hys_lsb = HYS_LSB_3;
      2'h3:    tecl_hys_lsb = HYS_LSB_6;
      default: tecl_hys_lsb = HYS_LSB_0;
    endcase
  endfunction

endpackage

// ==== hw/tecl_trip_unit.sv ====
// one hysteretic temperature trip comparator
// assumes temperature and limit are two's complement on the core clock, sampled on sampleValid
module tecl_trip_unit #(
  parameter bit RISING    = 1'b1,
  parameter bit INCLUSIVE = 1'b0
) (
  input  wire logic                       core_clk,
  input  wire logic                       sys_rst,
  input  wire logic                       hold,
  input  wire logic                       sampleValid,
  input  wire logic signed [12:0]         tempValue,
  input  wire logic signed [12:0]         limit,
  input  wire logic        [6:0]          hystLsb,
  output logic                            trip
);

  logic signed [13:0] tempExt;
  logic signed [13:0] limitExt;
  logic signed [13:0] limitLow;
  logic               setCond;
  logic               clrCond;
  logic               next_trip;

  // threshold pair; one extra bit keeps limit minus hysteresis from wrapping
  always_comb begin
    tempExt  = {tempValue[12], tempValue};
    limitExt = {limit[12], limit};
    limitLow = limitExt - $signed({7'h00, hystLsb});
    if (RISING) begin
      setCond = INCLUSIVE ? (tempExt >= limitExt) : (tempExt > limitExt);
      clrCond = INCLUSIVE ? (tempExt < limitLow) : (tempExt <= limitLow);
    end else begin
      setCond = tempExt < limitLow;
      clrCond = tempExt >= limitExt;
    end
    next_trip = trip;
    if (sampleValid && !hold) begin
      if (setCond) begin
        next_trip = 1'b1;
      end else if (clrCond) begin
        next_trip = 1'b0;
      end
    end
  end

  // trip state; held while sampling is stopped
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      trip <= 1'b0;
    end else begin
      trip <= next_trip;
    end
  end

endmodule

// ==== hw/tecl_event_ctrl.sv ====
// configuration register, trip limits and event pin control of the thermal sensor
// assumes the serial bus engine and converter share core_clk and present a decoded
// register port (pointer, write strobe, data) and a temperature sample with a valid strobe
//
// Overview of operation
// - interrupt mode: writing one to clear-event releases event until next trigger
// - comparator mode: register reads and clear-event writes never change the event output
// - comparator mode: event follows the trip state, re-evaluated against current limits
// - shutdown bit stops sampling and conversion; register port keeps answering
// - setting shutdown ignored while locked; clearing shutdown always accepted
// - clearing shutdown or power-on reset resumes continuous conversion
// - in shutdown registers stay accessible and no event condition is asserted
// - event-mode bit: zero comparator, one interrupt; frozen while either lock set
// - polarity bit: zero active-low, one active-high; frozen while either lock set
// - critical-only bit limits events to critical trip; frozen only by alarm lock
// - output-control bit enables event output; frozen while either lock set
// - event status bit reads one while this device asserts an event condition
// - clear-event reads zero and does nothing in comparator mode
// - alarm lock set by one write, reads one, freezes window limits until reset
// - critical lock set by one write, reads one, freezes critical limit until reset
// - hysteresis field codes none, 1.5, 3, 6 degrees; frozen while either lock set
// - selected hysteresis applies to the event pin and to the trip status bits
// - below-window and above-window bits set and clear with hysteresis on one side
// - above and critical thresholds deassert using the configured hysteresis; below deasserts at its limit
// - critical event behaves as comparator; clear-event cannot release it
module tecl_event_ctrl #(
  parameter logic [15:0] MANUF_ID = 16'h5A5A,  // arbitrary neutral value
  parameter logic [15:0] DEV_REV  = 16'h0A0A   // arbitrary neutral value
) (
  input  wire logic                       core_clk,
  input  wire logic                       sys_rst,
  input  wire logic                       regWrEn,
  input  wire logic        [2:0]          regAddr,
  input  wire logic        [15:0]         regWrData,
  output logic             [15:0]         regRdData,
  input  wire logic                       sampleValid,
  input  wire logic signed [12:0]         tempValue,
  output logic                            convEnable,
  output logic             [2:0]          tripStatus,
  output logic                            eventOut,
  output logic                            eventOe
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  tecl_pkg::tecl_cfg_s  cfg;
  tecl_pkg::tecl_cfg_s  next_cfg;
  logic [15:0]          limUpper;
  logic [15:0]          limLower;
  logic [15:0]          limCrit;
  logic [15:0]          next_limUpper;
  logic [15:0]          next_limLower;
  logic [15:0]          next_limCrit;
  tecl_pkg::tecl_int_e  intState;
  tecl_pkg::tecl_int_e  next_intState;
  logic [2:0]           tripPrev;
  logic [2:0]           next_tripPrev;
  logic [2:0]           trips;
  logic [12:0]          limitVal [tecl_pkg::TRIP_N];
  logic [6:0]           hystLsb;
  logic                 locked;
  logic                 cfgWr;
  logic                 clearReq;
  logic                 trigger;
  logic                 pending;
  logic                 pinActive;
  logic                 pinLevel;
  logic [15:0]          cfgRead;
  logic [15:0]          next_regRdData;
  logic                 next_eventOe;
  logic                 next_convEnable;
  logic [2:0]           next_tripStatus;

  // ---------------------------------------------------------------
  // trip comparators
  // ---------------------------------------------------------------
  // one hysteresis value feeds every comparator, so status bits and pin agree
  assign hystLsb = tecl_pkg::tecl_hys_lsb(cfg.hyst);

  // limits seen by each comparator, indexed below, above, critical
  assign limitVal[tecl_pkg::TRIP_BELOW] = limLower[12:0];
  assign limitVal[tecl_pkg::TRIP_ABOVE] = limUpper[12:0];
  assign limitVal[tecl_pkg::TRIP_CRIT]  = limCrit[12:0];

  // sampling is held in shutdown; trips keep their last state
  genvar gi;
  generate
    for (gi = 0; gi < tecl_pkg::TRIP_N; gi = gi + 1) begin : gTrip
      tecl_trip_unit #(
        .RISING    (tecl_pkg::TRIP_RISING[gi]),
        .INCLUSIVE (tecl_pkg::TRIP_INCLUDE[gi])
      ) uTrip (
        .core_clk    (core_clk),
        .sys_rst     (sys_rst),
        .hold        (cfg.shutdown),
        .sampleValid (sampleValid),
        .tempValue   (tempValue),
        .limit       ($signed(limitVal[gi])),
        .hystLsb     (hystLsb),
        .trip        (trips[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // configuration and limit registers
  // ---------------------------------------------------------------
  // either lock freezes most configuration fields
  assign locked = cfg.alarmLock | cfg.critLock;
  assign cfgWr  = regWrEn && (regAddr == tecl_pkg::PTR_SENSOR_CONFIGURATION);

  // field-wise write filter; fields not named keep their value
  always_comb begin
    next_cfg      = cfg;
    next_limUpper = limUpper;
    next_limLower = limLower;
    next_limCrit  = limCrit;
    if (cfgWr) begin
      if (!locked) begin
        next_cfg.evtMode  = regWrData[tecl_pkg::CFG_MODE_BIT];
        next_cfg.polarity = regWrData[tecl_pkg::CFG_POLARITY_BIT];
        next_cfg.outCtl   = regWrData[tecl_pkg::CFG_OUTCTL_BIT];
        next_cfg.hyst     = regWrData[tecl_pkg::CFG_HYST_HI:tecl_pkg::CFG_HYST_LO];
      end
      if (!cfg.alarmLock) begin
        next_cfg.critOnly = regWrData[tecl_pkg::CFG_CRITONLY_BIT];
      end
      // clearing always goes through, setting only while unlocked
      if (!regWrData[tecl_pkg::CFG_SHDN_BIT]) begin
        next_cfg.shutdown = 1'b0;
      end else if (!locked) begin
        next_cfg.shutdown = 1'b1;
      end
      // locks are sticky: a written zero does not release them
      if (regWrData[tecl_pkg::CFG_ALOCK_BIT]) begin
        next_cfg.alarmLock = 1'b1;
      end
      if (regWrData[tecl_pkg::CFG_CLOCK_BIT]) begin
        next_cfg.critLock = 1'b1;
      end
    end
    // unused upper bits are stored as zero so they read back as zero
    if (regWrEn && (regAddr == tecl_pkg::PTR_UPPER) && !cfg.alarmLock) begin
      next_limUpper = regWrData & tecl_pkg::LIMIT_MASK;
    end
    if (regWrEn && (regAddr == tecl_pkg::PTR_LOWER) && !cfg.alarmLock) begin
      next_limLower = regWrData & tecl_pkg::LIMIT_MASK;
    end
    if (regWrEn && (regAddr == tecl_pkg::PTR_CRIT) && !cfg.critLock) begin
      next_limCrit = regWrData & tecl_pkg::LIMIT_MASK;
    end
  end

  // power-on reset is the only path that clears the locks
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cfg      <= tecl_pkg::tecl_cfg_s'(tecl_pkg::CFG_RESET[8:0]);
      limUpper <= tecl_pkg::LIMIT_RESET;
      limLower <= tecl_pkg::LIMIT_RESET;
      limCrit  <= tecl_pkg::LIMIT_RESET;
    end else begin
      cfg      <= next_cfg;
      limUpper <= next_limUpper;
      limLower <= next_limLower;
      limCrit  <= next_limCrit;
    end
  end

  // ---------------------------------------------------------------
  // interrupt latch
  // ---------------------------------------------------------------
  // clear only counts in interrupt mode; in comparator mode it is a no-op
  assign clearReq = cfgWr && regWrData[tecl_pkg::CFG_CLEAR_BIT] && cfg.evtMode;

  // entering or leaving the window is a trigger; ignored when only critical counts
  assign trigger = !cfg.shutdown && !cfg.critOnly && cfg.evtMode &&
                   ((trips[tecl_pkg::TRIP_ABOVE] ^ tripPrev[tecl_pkg::TRIP_ABOVE]) |
                    (trips[tecl_pkg::TRIP_BELOW] ^ tripPrev[tecl_pkg::TRIP_BELOW]));

  // a trigger in the clear cycle wins, so no crossing is lost
  always_comb begin
    next_tripPrev = trips;
    next_intState = intState;
    case (intState)
      tecl_pkg::INT_IDLE: begin
        if (trigger) begin
          next_intState = tecl_pkg::INT_PENDING;
        end
      end
      tecl_pkg::INT_PENDING: begin
        if (!cfg.evtMode) begin
          next_intState = tecl_pkg::INT_IDLE;
        end else if (clearReq && !trigger) begin
          next_intState = tecl_pkg::INT_IDLE;
        end
      end
      default: begin
        next_intState = tecl_pkg::INT_IDLE;
      end
    endcase
  end

  // latch state and previous trips for edge detection
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      intState <= tecl_pkg::INT_IDLE;
      tripPrev <= 3'h0;
    end else begin
      intState <= next_intState;
      tripPrev <= next_tripPrev;
    end
  end

  // ---------------------------------------------------------------
  // event condition and pin
  // ---------------------------------------------------------------
  // comparator mode reads trips only, so reads and clear-event writes cannot move the pin
  always_comb begin
    if (cfg.shutdown) begin
      pending = 1'b0;
    end else if (cfg.evtMode) begin
      // critical stays asserted whatever clear-event does
      pending = (intState == tecl_pkg::INT_PENDING) | trips[tecl_pkg::TRIP_CRIT];
    end else if (cfg.critOnly) begin
      pending = trips[tecl_pkg::TRIP_CRIT];
    end else begin
      pending = |trips;
    end
  end

  // open-drain: the pin is pulled low when its level is zero, released otherwise;
  // an active-high idle pin therefore sinks pull-up current continuously
  assign pinActive = cfg.outCtl & pending;
  assign pinLevel  = cfg.polarity ? pinActive : ~pinActive;

  always_comb begin
    next_eventOe    = ~pinLevel;
    next_convEnable = ~cfg.shutdown;
    next_tripStatus = trips;
  end

  // pin and side outputs registered for clean timing
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      eventOe    <= 1'b0;
      eventOut   <= 1'b0;
      convEnable <= 1'b0;
      tripStatus <= 3'h0;
    end else begin
      eventOe    <= next_eventOe;
      eventOut   <= 1'b0;
      convEnable <= next_convEnable;
      tripStatus <= next_tripStatus;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // configuration image; clear-event always reads back as zero
  always_comb begin
    cfgRead = 16'h0000;
    cfgRead[tecl_pkg::CFG_MODE_BIT]     = cfg.evtMode;
    cfgRead[tecl_pkg::CFG_POLARITY_BIT] = cfg.polarity;
    cfgRead[tecl_pkg::CFG_CRITONLY_BIT] = cfg.critOnly;
    cfgRead[tecl_pkg::CFG_OUTCTL_BIT]   = cfg.outCtl;
    cfgRead[tecl_pkg::CFG_STATUS_BIT]   = pending;
    cfgRead[tecl_pkg::CFG_CLEAR_BIT]    = 1'b0;
    cfgRead[tecl_pkg::CFG_ALOCK_BIT]    = cfg.alarmLock;
    cfgRead[tecl_pkg::CFG_CLOCK_BIT]    = cfg.critLock;
    cfgRead[tecl_pkg::CFG_SHDN_BIT]     = cfg.shutdown;
    cfgRead[tecl_pkg::CFG_HYST_HI:tecl_pkg::CFG_HYST_LO] = cfg.hyst;
  end

  // read data follows the pointer one cycle later, also in shutdown
  always_comb begin
    case (regAddr)
      tecl_pkg::PTR_CAPA:  next_regRdData = tecl_pkg::CAPA_VALUE;
      tecl_pkg::PTR_SENSOR_CONFIGURATION:  next_regRdData = cfgRead;
      tecl_pkg::PTR_UPPER: next_regRdData = limUpper;
      tecl_pkg::PTR_LOWER: next_regRdData = limLower;
      tecl_pkg::PTR_CRIT:  next_regRdData = limCrit;
      tecl_pkg::PTR_TEMP:  next_regRdData = {trips[tecl_pkg::TRIP_CRIT],
                                             trips[tecl_pkg::TRIP_ABOVE],
                                             trips[tecl_pkg::TRIP_BELOW],
                                             tempValue};
      tecl_pkg::PTR_MANU:  next_regRdData = MANUF_ID;
      tecl_pkg::PTR_DEVID: next_regRdData = DEV_REV;
      default:             next_regRdData = 16'h0000;
    endcase
  end

  // registered read data
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      regRdData <= 16'h0000;
    end else begin
      regRdData <= next_regRdData;
    end
  end

endmodule

// ==== bench/tecl_host_model.sv ====
// host side of the event pin: an open-drain wire with a pull-up
// assumes the sensor sinks the pin only while its output enable is high
module tecl_host_model (
  input  wire logic eventOut,
  input  wire logic eventOe,
  output logic      pinLevel
);
  timeunit 1ns;
  timeprecision 100ps;
  // the pull-up wins whenever the sensor lets go, so a released pin never holds a stale level
  assign pinLevel = eventOe ? eventOut : 1'b1;
endmodule

// ==== bench/tecl_event_ctrl_asserts.sv ====
// port-level checker of the event control block
// assumes single-cycle writes and no limit write in the cycle of a sample
module tecl_event_ctrl_asserts (
  input wire logic               core_clk,
  input wire logic               sys_rst,
  input wire logic               regWrEn,
  input wire logic        [2:0]  regAddr,
  input wire logic        [15:0] regWrData,
  input wire logic        [15:0] regRdData,
  input wire logic               sampleValid,
  input wire logic signed [12:0] tempValue,
  input wire logic               convEnable,
  input wire logic        [2:0]  tripStatus,
  input wire logic               eventOut,
  input wire logic               eventOe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  // ----
  // shadow of locks, shutdown and the upper and critical trip limits
  // ----
  logic        [1:0]  locks;
  logic               shd;
  logic signed [12:0] upr;
  logic signed [12:0] crt;
  // shutdown set is judged against the locks held before the write
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      locks <= 2'h0;
      shd   <= 1'b0;
      upr   <= 13'h0000;
      crt   <= 13'h0000;
    end else if (regWrEn) begin
      if (regAddr == 3'h1) begin
        locks <= locks | regWrData[7:6];
        if (locks == 2'h0 || !regWrData[8]) shd <= regWrData[8];
      end
      if (regAddr == 3'h2 && !locks[0]) upr <= regWrData[12:0];
      if (regAddr == 3'h4 && !locks[1]) crt <= regWrData[12:0];
    end
  end
  // ----
  // assertions
  // ----
  AST_RST_PIN: assert property ($fell(sys_rst) |-> !eventOe)
    else $error("event pin driven right after reset");
  AST_SHDN_CONV: assert property (shd |=> !convEnable)
    else $error("converter running in shutdown");
  AST_RUN_CONV: assert property (!shd |=> convEnable)
    else $error("converter stopped outside shutdown");
  AST_SHDN_NOEVT: assert property ((shd && regAddr == 3'h1) [*3] |-> !regRdData[4])
    else $error("event status set in shutdown");
  AST_CLR_ZERO: assert property ($past(regAddr) == 3'h1 |-> !regRdData[5])
    else $error("clear bit reads one");
  AST_LOCK_READ: assert property ($past(regAddr) == 3'h1 |-> regRdData[7:6] == $past(locks))
    else $error("lock bits read wrong");
  AST_ABOVE_SET: assert property (sampleValid && !shd && tempValue > upr |-> ##2 tripStatus[1])
    else $error("above trip missing");
  AST_CRIT_SET: assert property (sampleValid && !shd && tempValue >= crt |-> ##2 tripStatus[2])
    else $error("critical trip missing");
  cover property (sampleValid && !shd && tempValue >= crt);
  cover property (regWrEn && regAddr == 3'h1 && regWrData[5]);
  cover property (shd && locks != 2'h0);
endmodule

bind tecl_event_ctrl tecl_event_ctrl_asserts chk_u (
  .core_clk, .sys_rst, .regWrEn, .regAddr, .regWrData, .regRdData, .sampleValid,
  .tempValue, .convEnable, .tripStatus, .eventOut, .eventOe
);

// ==== bench/tb.sv ====
// self-checking bench of the event control block
// assumes the checker is bound in and the host model resolves the event pin
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ----
  // signals and the table of ordinary cases
  // ----
  typedef struct packed {
    logic [15:0] cfg;
    logic [12:0] temp;
    logic [2:0]  trip;
    logic        oe;
    logic        st;
  } tecl_row_s;
  logic               core_clk, sys_rst, regWrEn, sampleValid;
  logic               convEnable, eventOut, eventOe, pinLevel;
  logic        [2:0]  regAddr, tripStatus;
  logic        [15:0] regWrData, regRdData;
  logic signed [12:0] tempValue;
  int                 n_mismatch = 0;
  int                 tests_run = 0;
  int                 cycles = 0;
  // limits: upper 0190, lower 0050, critical 0320; one sample after reset
  tecl_row_s rows [12] = '{
    '{16'h0008, 13'h0191, 3'h2, 1'h1, 1'h1},
    '{16'h0008, 13'h0190, 3'h0, 1'h0, 1'h0},
    '{16'h000A, 13'h0191, 3'h2, 1'h0, 1'h1},
    '{16'h0002, 13'h0100, 3'h0, 1'h1, 1'h0},
    '{16'h000C, 13'h0191, 3'h2, 1'h0, 1'h0},
    '{16'h000C, 13'h0320, 3'h6, 1'h1, 1'h1},
    '{16'h0009, 13'h0191, 3'h2, 1'h1, 1'h1},
    '{16'h000D, 13'h0191, 3'h2, 1'h0, 1'h0},
    '{16'h0208, 13'h0037, 3'h1, 1'h1, 1'h1},
    '{16'h0408, 13'h001F, 3'h1, 1'h1, 1'h1},
    '{16'h0608, 13'h1FF0, 3'h0, 1'h0, 1'h0},
    '{16'h0000, 13'h004F, 3'h1, 1'h0, 1'h1}
  };
  tecl_event_ctrl dut_u (
    .core_clk, .sys_rst, .regWrEn, .regAddr, .regWrData, .regRdData, .sampleValid,
    .tempValue, .convEnable, .tripStatus, .eventOut, .eventOe
  );
  tecl_host_model host_u (.eventOut, .eventOe, .pinLevel);
  // 200 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // hang guard; the run needs under 2000 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      summarize();
    end
  end
  // ----
  // tasks
  // ----
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one-cycle write strobe, inputs move 1 ns after the edge
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge core_clk) #1;
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = d;
    @(posedge core_clk) #1;
    regWrEn = 1'b0;
  endtask
  // read data follows the pointer one edge later; two edges cover a write just before
  task automatic rdc(input string what, input logic [2:0] a, input logic [15:0] exp);
    regAddr = a;
    repeat (2) @(posedge core_clk);
    #1;
    chk(what, regRdData, exp);
  endtask
  // eventOe may lag the sample by three edges, so wait four
  task automatic smp(input logic [12:0] t);
    @(posedge core_clk) #1;
    sampleValid = 1'b1;
    tempValue = t;
    @(posedge core_clk) #1;
    sampleValid = 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
  endtask
  task automatic rst0();
    sys_rst = 1'b1;
    repeat (6) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    @(posedge core_clk) #1;
  endtask
  task automatic setup(input logic [15:0] cfg);
    rst0();
    wr(3'h2, 16'h0190);
    wr(3'h3, 16'h0050);
    wr(3'h4, 16'h0320);
    wr(3'h1, cfg);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    sys_rst = 1'b1;
    regWrEn = 1'b0;
    regAddr = 3'h0;
    regWrData = 16'h0000;
    sampleValid = 1'b0;
    tempValue = 13'h0000;
    // reset values, a read-only place and limit padding
    rst0();
    chk("conv", convEnable, 1'b1);
    chk("oe", eventOe, 1'b0);
    chk("data", eventOut, 1'b0);
    rdc("sensor_configuration", 3'h1, tecl_pkg::CFG_RESET);
    wr(3'h0, 16'hFFFF);
    rdc("capa", 3'h0, tecl_pkg::CAPA_VALUE);
    wr(3'h2, 16'hFFFF);
    rdc("upper", 3'h2, tecl_pkg::LIMIT_MASK);
    $display("reset test done");
    // ordinary cases: modes, polarity, enable, critical-only, hysteresis codes
    foreach (rows[i]) begin
      setup(rows[i].cfg);
      smp(rows[i].temp);
      chk("trip", tripStatus, rows[i].trip);
      chk("oe", eventOe, rows[i].oe);
      chk("pin", pinLevel, !rows[i].oe);
      rdc("sensor_configuration", 3'h1, rows[i].cfg | {11'h000, rows[i].st, 4'h0});
      $display("row %0d done", i);
    end
    // interrupt latch, software clear, new trigger, critical hold
    setup(16'h0009);
    smp(13'h0191);
    wr(3'h1, 16'h0029);
    rdc("sensor_configuration", 3'h1, 16'h0009);
    chk("oe", eventOe, 1'b0);
    smp(13'h0100);
    chk("oe", eventOe, 1'b1);
    smp(13'h0320);
    wr(3'h1, 16'h0029);
    rdc("sensor_configuration", 3'h1, 16'h0019);
    chk("oe", eventOe, 1'b1);
    $display("interrupt test done");
    // comparator ignores bus traffic and follows rewritten limits
    setup(16'h0008);
    smp(13'h0191);
    wr(3'h1, 16'h0028);
    rdc("sensor_configuration", 3'h1, 16'h0018);
    chk("oe", eventOe, 1'b1);
    wr(3'h2, 16'h0200);
    rdc("upper", 3'h2, 16'h0200);
    chk("oe", eventOe, 1'b1);
    smp(13'h0191);
    chk("oe", eventOe, 1'b0);
    $display("comparator test done");
    // both locks freeze fields and limits
    setup(16'h0008);
    wr(3'h1, 16'h00C8);
    rdc("sensor_configuration", 3'h1, 16'h00C8);
    wr(3'h1, 16'h07C7);
    rdc("sensor_configuration", 3'h1, 16'h00C8);
    wr(3'h1, 16'h0000);
    rdc("sensor_configuration", 3'h1, 16'h00C8);
    wr(3'h2, 16'h0123);
    rdc("upper", 3'h2, 16'h0190);
    wr(3'h4, 16'h0123);
    rdc("crit", 3'h4, 16'h0320);
    $display("lock test done");
    // shutdown with a pending event, then clear while locked
    setup(16'h0008);
    smp(13'h0191);
    wr(3'h1, 16'h0148);
    rdc("sensor_configuration", 3'h1, 16'h0148);
    chk("conv", convEnable, 1'b0);
    chk("oe", eventOe, 1'b0);
    wr(3'h4, 16'h0300);
    rdc("crit", 3'h4, 16'h0300);
    smp(13'h0100);
    chk("trip", tripStatus, 3'h2);
    wr(3'h1, 16'h0048);
    rdc("sensor_configuration", 3'h1, 16'h0058);
    chk("conv", convEnable, 1'b1);
    wr(3'h1, 16'h0148);
    rdc("sensor_configuration", 3'h1, 16'h0058);
    $display("shutdown test done");
    summarize();
  end
endmodule
